//--- link_ctrl_pkg.sv
// Constants for the link protocol control register and cycle timer
package link_ctrl_pkg;
	localparam logic [7:0] link_ctrl_set_offset = 8'he0;
	localparam logic [7:0] link_ctrl_clear_offset = 8'he4;
	localparam int rollover_source_pos = 22;
	localparam int cycle_gen_en_pos = 21;
	localparam int offset_count_en_pos = 20;
	localparam int accept_phy_pos = 10;
	localparam int accept_self_id_pos = 9;
	localparam int filter_force_pos = 6;
	localparam int overlong_flag_pos = 25;
	localparam logic [31:0] link_ctrl_writable_mask = 32'h0070_0640;
	localparam logic [31:0] link_ctrl_reset_value = 32'h0000_0000;
	localparam int cycle_offset_width = 12;
	localparam logic [11:0] cycle_offset_last = 12'hbff;
	localparam logic [11:0] cycle_offset_reset_value = 12'h000;
	localparam int iso_rx_contexts = 4;
endpackage

//--- link_protocol_control.sv
// Link protocol control register with cycle timer offset logic
// Behaviour
// RL1: Source bit 1: cycle timer rolls over on external cycle input.
// RL2: Source bit 0: roll over after 3072 cycles of 24.576 MHz.
// RL3: Generator enable 1: send cycle start on every rollover.
// RL4: Generator enable 0: resync to received cycle start packets.
// RL5: Overlong-cycle flag set clears the generator enable bit.
// RL6: Setting generator enable is ignored while overlong flag stands.
// RL7: Count enable 1: offset advances each cycle clock and rolls over.
// RL8: Count enable 0: offset holds its value. Code still loads a received cycle start offset when generator enable is 0.
// RL9: Accept-PHY bit lets PHY packets into enabled request context.
// RL10: Accept-PHY bit never affects self-ID reception.
// RL11: Accept-self-ID bit gates self-ID packet reception.
// RL12: Software loads self-ID buffer pointer before enabling self-ID.
// RL13: Force bit 1 holds tag-one filter bit set in every context.
// RL14: Force bit 0 leaves tag-one filter bits freely writable.
// RL15: Force bit is set-only; cleared only by global reset.
// RL16: Reserved bits read zero, writes ignored.
// RL17: Set and clear addresses; either reads current contents.
// RL18: Zero written at either address leaves the bit unchanged.
`timescale 1ns/10ps
`default_nettype none
module link_protocol_control (
	input wire logic core_clk_in, // Link clock, 24.576 MHz cycle rate
	input wire logic rst_b_in, // Global hardware reset, active low
	input wire logic [7:0] reg_addr_in, // Register byte offset
	input wire logic reg_write_in, // Write strobe
	input wire logic [31:0] reg_wdata_in, // Write data
	output logic [31:0] reg_rdata_out, // Read data
	input wire logic overlong_cycle_flag_in, // Overlong-cycle event flag
	input wire logic external_cycle_input_in, // External cycle pin
	input wire logic cycle_start_rx_in, // Received cycle start pulse
	input wire logic [11:0] cycle_start_offset_in, // Offset in that packet
	input wire logic [3:0] filter_sw_bit_in, // Software tag-one bits
	output logic [3:0] tag_one_filter_bit_out, // Effective tag-one bits
	output logic [11:0] cycle_offset_out, // Cycle timer offset
	output logic cycle_rollover_out, // Rollover pulse
	output logic send_cycle_start_out, // Request cycle start packet
	output logic accept_phy_packets_out, // PHY packet receive gate
	output logic accept_self_id_packets_out // Self-ID receive gate
);
	import link_ctrl_pkg::*;

	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [11:0] offset_reg;
	logic [2:0] ext_sync_reg;
	logic ext_level_reg;
	logic ext_rise;
	logic rollover_source_select;
	logic cycle_start_generator_en;
	logic cycle_offset_count_en;
	logic roll;
	logic set_wr;
	logic clr_wr;
	logic [31:0] set_bits;

	assign rollover_source_select = ctrl_reg[rollover_source_pos];
	assign cycle_start_generator_en = ctrl_reg[cycle_gen_en_pos];
	assign cycle_offset_count_en = ctrl_reg[offset_count_en_pos];
	assign set_wr = reg_write_in && reg_addr_in == link_ctrl_set_offset;
	assign clr_wr = reg_write_in && reg_addr_in == link_ctrl_clear_offset;

	always_comb begin
		set_bits = reg_wdata_in & link_ctrl_writable_mask; // RL16
		if (overlong_cycle_flag_in) begin
			set_bits[cycle_gen_en_pos] = 1'b0; // RL6
		end
		ctrl_next = ctrl_reg;
		if (set_wr) begin
			ctrl_next = ctrl_reg | set_bits; // RL17 RL18
		end
		if (clr_wr) begin
			// Force bit is set-only
			ctrl_next = ctrl_reg & ~(set_bits & ~(32'h1 << filter_force_pos)); // RL15
			ctrl_next[cycle_gen_en_pos] = ctrl_reg[cycle_gen_en_pos] &
				~reg_wdata_in[cycle_gen_en_pos]; // RL17
		end
		if (overlong_cycle_flag_in) begin
			ctrl_next[cycle_gen_en_pos] = 1'b0; // RL5
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			ctrl_reg <= link_ctrl_reset_value; // RL15
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	always_comb begin
		reg_rdata_out = 32'h0;
		if (reg_addr_in == link_ctrl_set_offset ||
			reg_addr_in == link_ctrl_clear_offset) begin
			reg_rdata_out = ctrl_reg & link_ctrl_writable_mask; // RL16 RL17
		end
	end

	// Pin synchroniser; second and third stages must agree
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			ext_sync_reg <= 3'h0;
			ext_level_reg <= 1'b0;
		end else begin
			ext_sync_reg <= {ext_sync_reg[1:0], external_cycle_input_in};
			if (ext_sync_reg[1] == ext_sync_reg[2]) begin
				ext_level_reg <= ext_sync_reg[2];
			end
		end
	end
	assign ext_rise = ext_sync_reg[1] && ext_sync_reg[2] && !ext_level_reg;

	always_comb begin
		if (rollover_source_select) begin
			roll = cycle_offset_count_en && ext_rise; // RL1
		end else begin
			roll = cycle_offset_count_en && offset_reg == cycle_offset_last; // RL2
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			offset_reg <= cycle_offset_reset_value;
		end else if (!cycle_start_generator_en && cycle_start_rx_in) begin
			offset_reg <= cycle_start_offset_in; // RL4
		end else if (roll) begin
			offset_reg <= cycle_offset_reset_value; // RL7
		end else if (cycle_offset_count_en && offset_reg != cycle_offset_last) begin
			offset_reg <= offset_reg + 12'h001; // RL7
		end
		// Count disabled: offset holds unless generator enable is 0 and a cycle start is received. RL8
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			cycle_rollover_out <= 1'b0;
			send_cycle_start_out <= 1'b0;
		end else begin
			cycle_rollover_out <= roll;
			send_cycle_start_out <= roll && cycle_start_generator_en; // RL3
		end
	end

	assign cycle_offset_out = offset_reg;
	assign accept_phy_packets_out = ctrl_reg[accept_phy_pos]; // RL9 RL10
	assign accept_self_id_packets_out = ctrl_reg[accept_self_id_pos]; // RL11

	genvar ctx;
	generate
		for (ctx = 0; ctx < iso_rx_contexts; ctx++) begin : g_filter
			assign tag_one_filter_bit_out[ctx] =
				ctrl_reg[filter_force_pos] | filter_sw_bit_in[ctx]; // RL13 RL14
		end
	endgenerate
endmodule
`default_nettype wire

//--- link_protocol_control_asserts.sv
// Port-level checks for the link protocol control register
`timescale 1ns/10ps
`default_nettype none
module link_protocol_control_asserts import link_ctrl_pkg::*; (
	input wire logic core_clk_in, // Clock
	input wire logic rst_b_in, // Reset
	input wire logic [7:0] reg_addr_in, // Offset
	input wire logic reg_write_in, // Strobe
	input wire logic [31:0] reg_wdata_in, // Write data
	input wire logic [31:0] reg_rdata_out, // Read data
	input wire logic overlong_cycle_flag_in, // Overlong flag
	input wire logic cycle_start_rx_in, // Rx start
	input wire logic [3:0] filter_sw_bit_in, // Sw bits
	input wire logic [3:0] tag_one_filter_bit_out, // Bits out
	input wire logic [11:0] cycle_offset_out, // Offset
	input wire logic accept_phy_packets_out // Phy gate
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	wire logic at_set = reg_addr_in == link_ctrl_set_offset;
	wire logic at_clr = reg_addr_in == link_ctrl_clear_offset;
	sequence s_forced;
		tag_one_filter_bit_out == 4'hf && filter_sw_bit_in != 4'hf;
	endsequence
	property p_rsvd;
		(reg_rdata_out & ~link_ctrl_writable_mask) == 32'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_ovl;
		overlong_cycle_flag_in && $past(overlong_cycle_flag_in) && at_set
			|-> !reg_rdata_out[21];
	endproperty
	a_ovl: assert property (p_ovl) else $error("master bit kept");
	property p_filter;
		at_set |-> tag_one_filter_bit_out ==
			(filter_sw_bit_in | {4{reg_rdata_out[6]}});
	endproperty
	a_filter: assert property (p_filter) else $error("filter bits");
	property p_sticky;
		s_forced ##1 filter_sw_bit_in != 4'hf |-> tag_one_filter_bit_out == 4'hf;
	endproperty
	a_sticky: assert property (p_sticky) else $error("force lost");
	property p_wrap;
		at_set && reg_rdata_out[20] && !reg_rdata_out[22] && !cycle_start_rx_in
			&& cycle_offset_out == cycle_offset_last |=> cycle_offset_out == 12'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap");
	property p_mirror;
		at_set |-> accept_phy_packets_out == reg_rdata_out[10];
	endproperty
	a_mirror: assert property (p_mirror) else $error("phy gate");
	property p_setclr;
		reg_write_in && reg_wdata_in[10] && (at_set || at_clr)
			|=> accept_phy_packets_out == $past(at_set);
	endproperty
	a_setclr: assert property (p_setclr) else $error("set clear");
	property p_zero;
		reg_write_in && !reg_wdata_in[10] |=> $stable(accept_phy_packets_out);
	endproperty
	a_zero: assert property (p_zero) else $error("zero write");
endmodule
`default_nettype wire

//--- link_protocol_control_test.sv
// Directed test of the link protocol control register
`timescale 1ns/10ps
`default_nettype none
module link_protocol_control_test;
	import link_ctrl_pkg::*;
	logic clk = 0, rst_b = 0, wr = 0, ovl = 0, ext = 0, rx = 0;
	logic [7:0] addr = 8'he0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] sw = 4'h5, tag;
	logic [11:0] off, o1;
	logic roll, send, phy, sid;
	int n_errors = 0, samples_checked = 0, i;
	always #2.5 clk = ~clk;
	link_protocol_control i_dut (.core_clk_in(clk), .rst_b_in(rst_b),
		.reg_addr_in(addr), .reg_write_in(wr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .overlong_cycle_flag_in(ovl),
		.external_cycle_input_in(ext), .cycle_start_rx_in(rx),
		.cycle_start_offset_in(12'h123), .filter_sw_bit_in(sw),
		.tag_one_filter_bit_out(tag), .cycle_offset_out(off),
		.cycle_rollover_out(roll), .send_cycle_start_out(send),
		.accept_phy_packets_out(phy), .accept_self_id_packets_out(sid));
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(logic [7:0] a, logic [31:0] d);
		addr = a;
		wdata = d;
		wr = 1;
		cyc(1);
		wr = 0;
		addr = 8'he0;
		// Idle cycle so back-to-back calls drop the strobe for one cycle between writes
		cyc(1);
	endtask
	task automatic finish_test();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		n_errors++;
		finish_test();
	end
	initial begin
		cyc(2);
		rst_b = 1;
		chk("reset", rdata, link_ctrl_reset_value);
		// Self-ID buffer pointer taken as loaded before this set
		wr_reg(8'he0, 32'hffff_ffff);
		chk("set", rdata, link_ctrl_writable_mask);
		chk("gates", {phy, sid}, 2'b11);
		chk("tag", tag, 4'hf);
		o1 = off;
		cyc(10);
		chk("count", off, o1 + 12'd10);
		wr_reg(8'he4, 32'h0010_0000);
		o1 = off;
		cyc(10);
		chk("hold", off, o1);
		chk("keep", rdata, 32'h0060_0640);
		wr_reg(8'he4, 32'hffff_ffff);
		wr_reg(8'he8, 32'hffff_ffff);
		addr = 8'he4;
		#1 chk("sticky", rdata, 32'h0000_0040);
		addr = 8'he0;
		wr_reg(8'he0, 32'h0020_0000);
		ovl = 1;
		cyc(2);
		chk("ovl", rdata[21], 0);
		wr_reg(8'he0, 32'h0020_0000);
		chk("refused", rdata[21], 0);
		ovl = 0;
		cyc(1);
		wr_reg(8'he0, 32'h0030_0000);
		chk("master", rdata[21], 1);
		for (i = 0; i < 3200 && !roll; i++) cyc(1);
		for (i = 1; i < 3100; i++) begin
			cyc(1);
			if (roll === 1'b1) break;
		end
		chk("period", i, 3072);
		chk("send", send, 1);
		wr_reg(8'he4, 32'h0020_0000);
		rx = 1;
		cyc(1);
		rx = 0;
		chk("rxload", off, 12'h123);
		wr_reg(8'he0, 32'h0040_0000);
		ext = 1;
		for (i = 0; i < 8 && !roll; i++) cyc(1);
		chk("ext", roll, 1);
		ext = 0;
		rst_b = 0;
		cyc(2);
		rst_b = 1;
		chk("global_hw_reset", rdata, 32'h0);
		chk("free", tag, 4'h5);
		wr_reg(8'he0, 32'h0000_0400);
		chk("phyonly", {phy, sid}, 2'b10);
		finish_test();
	end
endmodule
bind link_protocol_control link_protocol_control_asserts i_chk (.core_clk_in,
	.rst_b_in, .reg_addr_in, .reg_write_in, .reg_wdata_in, .reg_rdata_out,
	.overlong_cycle_flag_in, .cycle_start_rx_in, .filter_sw_bit_in,
	.tag_one_filter_bit_out, .cycle_offset_out, .accept_phy_packets_out);
`default_nettype wire
